// ===== logic/mas_pkg.sv
// Constants, register map and encodings of the multiply-accumulate slice
package mas_pkg;
  // Datapath widths
  localparam int A_W = 25;
  localparam int B_W = 18;
  localparam int M_W = A_W + B_W;
  localparam int P_W = 48;
  localparam int LANE_W = 12;
  localparam int LANES = P_W / LANE_W;
  localparam int STEP_W = 32;
  // Wishbone register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STEP = 8'h04;
  localparam logic [7:0] OFS_PAT_LO = 8'h08;
  localparam logic [7:0] OFS_PAT_HI = 8'h0c;
  localparam logic [7:0] OFS_MSK_LO = 8'h10;
  localparam logic [7:0] OFS_MSK_HI = 8'h14;
  localparam logic [7:0] OFS_RES_LO = 8'h18;
  localparam logic [7:0] OFS_RES_HI = 8'h1c;
  // Control register fields
  localparam int C_BYP = 0;
  localparam int C_PRE = 1;
  localparam int C_SIMD = 2;
  localparam int C_OP = 4;
  localparam int C_LOGIC = 6;
  localparam int C_LFN = 7;
  localparam int C_INP = 11;
  localparam int C_MP = 12;
  localparam int C_YCAS = 13;
  localparam int C_DOWN = 14;
  localparam int C_RND = 15;
  localparam int C_RBIT = 16;
  localparam int CTRL_W = 22;
  // Result high word: match flags sit above the 16 result bits
  localparam int R_MATCH = 16;
  localparam int R_NMATCH = 17;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // Lane split of the adder
  typedef enum logic [1:0] {SIMD_ONE, SIMD_TWO, SIMD_FOUR} mas_simd_t;
  // Arithmetic operation
  typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_ACC, OP_CNT} mas_op_t;
  // Ten bitwise functions of x and y
  typedef enum logic [3:0] {
    LF_AND, LF_OR, LF_XOR, LF_NAND, LF_NOR,
    LF_XNOR, LF_ANDN, LF_ORN, LF_NOTX, LF_PASSX
  } mas_lfn_t;
endpackage

// ===== logic/mas_slice.sv
// Multiply-accumulate slice with SIMD adder, logic unit and pattern detector
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
// Functional notes
// - Signed 25x18 multiply, 48-bit accumulate.
// - Dynamic multiplier bypass feeds two 48-bit operands.
// - SIMD: one, two or four carry-isolated lanes.
// - Logic unit offers ten bitwise functions.
// - Optional pre-adder sums operands before multiply.
// - Pattern detector on output drives convergent rounding.
// - Detector plus logic unit gives 96-bit functions.
// - Per-stage optional pipeline registers add latency.
// - Dedicated cascade input and output to neighbour.
// - Accumulator can count up or down by step.
module mas_slice (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Fabric operands
  input wire logic [mas_pkg::A_W-1:0] a_in,
  input wire logic [mas_pkg::A_W-1:0] d_in,
  input wire logic [mas_pkg::B_W-1:0] b_in,
  input wire logic [mas_pkg::P_W-1:0] c_in,
  input wire logic [mas_pkg::P_W-1:0] byp_in,
  input wire logic acc_en,
  // Cascade
  input wire logic [mas_pkg::P_W-1:0] cas_in,
  output logic [mas_pkg::P_W-1:0] cas_out,
  // Results
  output logic [mas_pkg::P_W-1:0] p_out,
  output logic match_out,
  output logic nmatch_out
);
  logic [31:0] ctrl_q, step_q, pat_lo_q, pat_hi_q, msk_lo_q, msk_hi_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [mas_pkg::A_W-1:0] a_q, d_q, a_s, d_s;
  logic [mas_pkg::B_W-1:0] b_q, b_s;
  logic [mas_pkg::P_W-1:0] c_q, byp_q, c_s, byp_s, cas_q, cas_s;
  logic [mas_pkg::A_W-1:0] pre;
  logic signed [mas_pkg::M_W-1:0] prod;
  logic [mas_pkg::P_W-1:0] m_d, m_q, m_s;
  logic [mas_pkg::P_W-1:0] x, y, xa, sum, lres, z, p_d, p_q;
  logic [mas_pkg::P_W-1:0] pat, msk, rbit_m;
  logic [mas_pkg::LANES-1:0] cin, cy;
  logic sub, det, ndet, match_q, nmatch_q;
  mas_pkg::mas_simd_t simd;
  mas_pkg::mas_op_t op;
  mas_pkg::mas_lfn_t lfn;
  logic wr, rd_req;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i+:8] = dat[8*i+:8];
      end
    end
    return r;
  endfunction

  // Configuration decode
  assign simd = mas_pkg::mas_simd_t'(ctrl_q[mas_pkg::C_SIMD+:2]);
  assign op = mas_pkg::mas_op_t'(ctrl_q[mas_pkg::C_OP+:2]);
  assign lfn = mas_pkg::mas_lfn_t'(ctrl_q[mas_pkg::C_LFN+:4]);
  assign pat = {pat_hi_q[15:0], pat_lo_q};
  assign msk = {msk_hi_q[15:0], msk_lo_q};

  // Bus handshake: every access is answered one cycle after the request
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
  assign rd_req = wb_cyc_i & wb_stb_i & ~ack_q;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= rd_req;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Writable registers; the write lands with the acknowledge edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q <= mas_pkg::CTRL_RST;
      step_q <= 32'h0000_0000;
      pat_lo_q <= 32'h0000_0000;
      pat_hi_q <= 32'h0000_0000;
      msk_lo_q <= 32'h0000_0000;
      msk_hi_q <= 32'h0000_0000;
    end else if (wr) begin
      unique case (wb_adr_i)
        mas_pkg::OFS_CTRL: ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) &
                                     32'((33'h1 << mas_pkg::CTRL_W) - 33'h1);
        mas_pkg::OFS_STEP: step_q <= merge(step_q, wb_dat_i, wb_sel_i);
        mas_pkg::OFS_PAT_LO: pat_lo_q <= merge(pat_lo_q, wb_dat_i, wb_sel_i);
        mas_pkg::OFS_PAT_HI: pat_hi_q <= merge(pat_hi_q, wb_dat_i, wb_sel_i) & 32'h0000_ffff;
        mas_pkg::OFS_MSK_LO: msk_lo_q <= merge(msk_lo_q, wb_dat_i, wb_sel_i);
        mas_pkg::OFS_MSK_HI: msk_hi_q <= merge(msk_hi_q, wb_dat_i, wb_sel_i) & 32'h0000_ffff;
        default: ;
      endcase
    end
  end

  // Read data is captured with the request so it is ready with ack
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdat_q <= 32'h0000_0000;
    end else if (rd_req) begin
      unique case (wb_adr_i)
        mas_pkg::OFS_CTRL: rdat_q <= ctrl_q;
        mas_pkg::OFS_STEP: rdat_q <= step_q;
        mas_pkg::OFS_PAT_LO: rdat_q <= pat_lo_q;
        mas_pkg::OFS_PAT_HI: rdat_q <= pat_hi_q;
        mas_pkg::OFS_MSK_LO: rdat_q <= msk_lo_q;
        mas_pkg::OFS_MSK_HI: rdat_q <= msk_hi_q;
        mas_pkg::OFS_RES_LO: rdat_q <= p_q[31:0];
        mas_pkg::OFS_RES_HI: rdat_q <= {14'h0, nmatch_q, match_q, p_q[47:32]};
        default: rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  // Input stage registers, bypassed when the stage is disabled
  always_ff @(posedge core_clk) begin
    if (srst) begin
      a_q <= '0;
      d_q <= '0;
      b_q <= '0;
      c_q <= '0;
      byp_q <= '0;
      cas_q <= '0;
    end else begin
      a_q <= a_in;
      d_q <= d_in;
      b_q <= b_in;
      c_q <= c_in;
      byp_q <= byp_in;
      cas_q <= cas_in;
    end
  end
  assign a_s = ctrl_q[mas_pkg::C_INP] ? a_q : a_in;
  assign d_s = ctrl_q[mas_pkg::C_INP] ? d_q : d_in;
  assign b_s = ctrl_q[mas_pkg::C_INP] ? b_q : b_in;
  assign c_s = ctrl_q[mas_pkg::C_INP] ? c_q : c_in;
  assign byp_s = ctrl_q[mas_pkg::C_INP] ? byp_q : byp_in;
  assign cas_s = ctrl_q[mas_pkg::C_INP] ? cas_q : cas_in;

  // Pre-adder and signed multiplier; pre-add result wraps at 25 bits
  assign pre = ctrl_q[mas_pkg::C_PRE] ? mas_pkg::A_W'(a_s + d_s) : a_s;
  assign prod = $signed(pre) * $signed(b_s);
  assign m_d = {{(mas_pkg::P_W - mas_pkg::M_W){prod[mas_pkg::M_W-1]}}, prod};

  // Multiplier stage register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      m_q <= '0;
    end else begin
      m_q <= m_d;
    end
  end
  assign m_s = ctrl_q[mas_pkg::C_MP] ? m_q : m_d;
  // Bypass swaps the product for the raw 48-bit operand
  assign x = ctrl_q[mas_pkg::C_BYP] ? byp_s : m_s;

  // Second operand: accumulator, cascade bus or fabric c
  always_comb begin
    if (op == mas_pkg::OP_ACC || op == mas_pkg::OP_CNT) begin
      y = p_q;
    end else if (ctrl_q[mas_pkg::C_YCAS]) begin
      y = cas_s;
    end else begin
      y = c_s;
    end
  end

  // Counter steps by the sign-extended step; subtract inverts x
  always_comb begin
    sub = (op == mas_pkg::OP_SUB) ||
          (op == mas_pkg::OP_CNT && ctrl_q[mas_pkg::C_DOWN]);
    if (op == mas_pkg::OP_CNT) begin
      xa = {{(mas_pkg::P_W - mas_pkg::STEP_W){step_q[31]}}, step_q};
    end else begin
      xa = x;
    end
    if (sub) begin
      xa = ~xa;
    end
  end

  // Lane adders; the carry chain breaks at every active lane start
  for (genvar i = 0; i < mas_pkg::LANES; i++) begin : g_lane
    if (i == 0) begin : g_first
      assign cin[i] = sub;
    end else begin : g_rest
      assign cin[i] = (simd == mas_pkg::SIMD_FOUR ||
                       (simd == mas_pkg::SIMD_TWO && i == mas_pkg::LANES / 2)) ?
                      sub : cy[i-1];
    end
    assign {cy[i], sum[i*mas_pkg::LANE_W+:mas_pkg::LANE_W]} =
      {1'b0, y[i*mas_pkg::LANE_W+:mas_pkg::LANE_W]} +
      {1'b0, xa[i*mas_pkg::LANE_W+:mas_pkg::LANE_W]} +
      {{mas_pkg::LANE_W{1'b0}}, cin[i]};
  end

  // Logic unit; codes above the ten functions give zero
  always_comb begin
    unique case (lfn)
      mas_pkg::LF_AND: lres = x & y;
      mas_pkg::LF_OR: lres = x | y;
      mas_pkg::LF_XOR: lres = x ^ y;
      mas_pkg::LF_NAND: lres = ~(x & y);
      mas_pkg::LF_NOR: lres = ~(x | y);
      mas_pkg::LF_XNOR: lres = ~(x ^ y);
      mas_pkg::LF_ANDN: lres = x & ~y;
      mas_pkg::LF_ORN: lres = x | ~y;
      mas_pkg::LF_NOTX: lres = ~x;
      mas_pkg::LF_PASSX: lres = x;
      default: lres = '0;
    endcase
  end
  assign z = ctrl_q[mas_pkg::C_LOGIC] ? lres : sum;

  // Masked compare; applied to a logic result it reduces 96 input bits
  assign det = &((z ~^ pat) | msk);
  assign ndet = &((z ~^ ~pat) | msk);
  // Exact half found by the detector: force the kept LSB even
  assign rbit_m = mas_pkg::P_W'(1) << ctrl_q[mas_pkg::C_RBIT+:6];
  assign p_d = (ctrl_q[mas_pkg::C_RND] && det) ? (z & ~rbit_m) : z;

  // Accumulator and detector flags move only on enabled clocks
  always_ff @(posedge core_clk) begin
    if (srst) begin
      p_q <= '0;
      match_q <= 1'b0;
      nmatch_q <= 1'b0;
    end else if (acc_en) begin
      p_q <= p_d;
      match_q <= det;
      nmatch_q <= ndet;
    end
  end
  assign p_out = p_q;
  assign cas_out = p_q;
  assign match_out = match_q;
  assign nmatch_out = nmatch_q;

  // Checks
  sequence s_req;
    wb_cyc_i && wb_stb_i && !ack_q;
  endsequence
  sequence s_ans;
    ack_q ##1 !ack_q;
  endsequence
  logic plain;
  assign plain = !ctrl_q[mas_pkg::C_INP] && !ctrl_q[mas_pkg::C_MP] &&
                 !ctrl_q[mas_pkg::C_RND] && !ctrl_q[mas_pkg::C_YCAS] && acc_en;

  AST_BUS_ANS: assert property (@(posedge core_clk) disable iff (srst)
    s_req |=> s_ans) else $error("ack not a single pulse after request");
  AST_RESET: assert property (@(posedge core_clk)
    srst |=> (p_q == '0 && !match_q && !nmatch_q && m_q == '0 && a_q == '0))
    else $error("reset did not clear state");
  AST_MULT: assert property (@(posedge core_clk) disable iff (srst)
    plain && !ctrl_q[mas_pkg::C_BYP] && !ctrl_q[mas_pkg::C_LOGIC] &&
    !ctrl_q[mas_pkg::C_PRE] && op == mas_pkg::OP_ADD && simd == mas_pkg::SIMD_ONE
    |=> $signed(p_q) == $signed($past(c_in)) + $signed($past(a_in)) * $signed($past(b_in)))
    else $error("multiply-add result wrong");
  AST_PRE: assert property (@(posedge core_clk) disable iff (srst)
    plain && !ctrl_q[mas_pkg::C_BYP] && !ctrl_q[mas_pkg::C_LOGIC] &&
    ctrl_q[mas_pkg::C_PRE] && op == mas_pkg::OP_ADD && c_in == '0 &&
    simd == mas_pkg::SIMD_ONE
    |=> $signed(p_q) ==
    $signed(mas_pkg::A_W'($past(a_in) + $past(d_in))) * $signed($past(b_in)))
    else $error("pre-adder product wrong");
  AST_SIMD: assert property (@(posedge core_clk) disable iff (srst)
    plain && ctrl_q[mas_pkg::C_BYP] && !ctrl_q[mas_pkg::C_LOGIC] &&
    simd == mas_pkg::SIMD_FOUR && op == mas_pkg::OP_ADD
    |=> p_q[23:12] == 12'($past(c_in[23:12]) + $past(byp_in[23:12])))
    else $error("carry crossed a lane");
  AST_LOGIC: assert property (@(posedge core_clk) disable iff (srst)
    plain && ctrl_q[mas_pkg::C_BYP] && ctrl_q[mas_pkg::C_LOGIC] &&
    lfn == mas_pkg::LF_XOR && op == mas_pkg::OP_ADD
    |=> p_q == ($past(byp_in) ^ $past(c_in))) else $error("logic unit wrong");
  AST_COUNT: assert property (@(posedge core_clk) disable iff (srst)
    acc_en && op == mas_pkg::OP_CNT && !ctrl_q[mas_pkg::C_DOWN] &&
    !ctrl_q[mas_pkg::C_LOGIC] && !ctrl_q[mas_pkg::C_RND] && simd == mas_pkg::SIMD_ONE
    |=> p_q == 48'($past(p_q) + {{16{$past(step_q[31])}}, $past(step_q)}))
    else $error("counter step wrong");
  AST_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    !acc_en |=> $stable(p_q)) else $error("accumulator moved while disabled");
  AST_PIPE: assert property (@(posedge core_clk) disable iff (srst)
    ctrl_q[mas_pkg::C_INP] && !ctrl_q[mas_pkg::C_PRE]
    |=> $signed(m_q) == $signed($past(a_in, 2)) * $signed($past(b_in, 2)))
    else $error("pipeline stage skipped");
  AST_MATCH: assert property (@(posedge core_clk) disable iff (srst)
    acc_en && !ctrl_q[mas_pkg::C_RND] |=> match_q == &((p_q ~^ $past(pat)) | $past(msk)))
    else $error("pattern flag disagrees with result");
  AST_CASC: assert property (@(posedge core_clk) disable iff (srst)
    plain && op == mas_pkg::OP_ADD && !ctrl_q[mas_pkg::C_LOGIC] && ctrl_q[mas_pkg::C_BYP] &&
    simd == mas_pkg::SIMD_ONE && byp_in == '0 |=> cas_out == $past(c_in))
    else $error("cascade output wrong");
endmodule

// ===== tb/mas_fabric_model.sv
// Neighbouring slice model on the far side of the cascade path
`timescale 1ns/1ps
module mas_fabric_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Load request from the bench
  input wire logic ld,
  input wire logic [47:0] ldv,
  // Cascade to and from the slice
  input wire logic [47:0] nb_in,
  output logic [47:0] casc_q,
  output logic [47:0] seen_q
);
  // Neighbour accumulator is a register, so the path never floats
  always_ff @(posedge core_clk) begin
    if (srst) begin
      casc_q <= 48'h0;
    end else if (ld) begin
      casc_q <= ldv;
    end
  end
  // Neighbour consumes the slice output one clock later
  always_ff @(posedge core_clk) begin
    seen_q <= nb_in;
  end
endmodule

// ===== tb/test_multiply_accumulate_slice.sv
// Self-checking bench of the multiply-accumulate slice
`timescale 1ns/1ps
module test_multiply_accumulate_slice;
  localparam logic [31:0] BYP = 32'h1 << mas_pkg::C_BYP;
  localparam logic [31:0] LOG = 32'h1 << mas_pkg::C_LOGIC;
  localparam logic [31:0] ACC = 32'h2 << mas_pkg::C_OP;
  localparam logic [31:0] CNT = 32'h3 << mas_pkg::C_OP;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, match_out, nmatch_out;
  logic acc_en = 1'b1;
  logic ld = 1'b0;
  logic [24:0] a_in = 25'h0;
  logic [24:0] d_in = 25'h0;
  logic [17:0] b_in = 18'h0;
  logic [47:0] c_in = 48'h0;
  logic [47:0] byp_in = 48'h0;
  logic [47:0] ldv = 48'h0;
  logic [47:0] cas_in, cas_out, p_out, seen, e;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  mas_slice uut (.core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .a_in(a_in), .d_in(d_in), .b_in(b_in),
    .c_in(c_in), .byp_in(byp_in), .acc_en(acc_en), .cas_in(cas_in), .cas_out(cas_out),
    .p_out(p_out), .match_out(match_out), .nmatch_out(nmatch_out));
  mas_fabric_model nbr (.core_clk(core_clk), .srst(srst), .ld(ld), .ldv(ldv),
    .nb_in(cas_out), .casc_q(cas_in), .seen_q(seen));
  // Free-running clock at 8 ns
  always #4 core_clk = ~core_clk;
  // Hang guard at 6000 cycles, well above the few hundred cycles needed
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [47:0] s, input logic [47:0] x);
    checks_done++;
    if (s !== x) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // Classic cycle: hold everything until ack is sampled high at a rising edge,
  // take read data at that edge and release right after it; only the hang guard
  // ends a wait that never sees ack
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic go(input logic [24:0] a, d, input logic [17:0] b,
      input logic [47:0] c, y, input int n);
    @(posedge core_clk);
    a_in <= a;
    d_in <= d;
    b_in <= b;
    c_in <= c;
    byp_in <= y;
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic en(input int n);
    @(posedge core_clk);
    acc_en <= 1'b1;
    repeat (n) @(posedge core_clk);
    acc_en <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rst();
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic t_reset();
    chk(p_out, 48'h0);
    chk({match_out, nmatch_out}, 48'h0);
    bus(1'b0, mas_pkg::OFS_CTRL, 32'h0);
    chk(rd, mas_pkg::CTRL_RST);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 48'h0);
  endtask
  task automatic t_mult();
    bus(1'b1, mas_pkg::OFS_CTRL, 32'h0);
    go(25'h1000000, 0, 18'h20000, 48'hffffffffffff, 0, 1);
    chk(p_out, 48'h01ffffffffff);
    bus(1'b1, mas_pkg::OFS_CTRL, 32'h1 << mas_pkg::C_OP);
    go(25'h3, 0, 18'h3fffb, 48'h0, 0, 1);
    chk(p_out, 48'hf);
    bus(1'b0, mas_pkg::OFS_RES_LO, 32'h0);
    chk(rd, 48'hf);
    @(posedge core_clk);
    acc_en <= 1'b0;
    go(25'h7, 0, 18'h7, 48'h0, 0, 2);
    chk(p_out, 48'hf);
    @(posedge core_clk);
    acc_en <= 1'b1;
  endtask
  task automatic t_pre();
    bus(1'b1, mas_pkg::OFS_CTRL, 32'h1 << mas_pkg::C_PRE);
    go(25'h0ffffff, 25'h1, 18'h1, 48'h0, 0, 1);
    chk(p_out, 48'hffffff000000);
  endtask
  task automatic t_simd();
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, mas_pkg::OFS_CTRL, BYP | (m << mas_pkg::C_SIMD));
      go(0, 0, 0, 48'hffffffffffff, 48'h001001001001, 1);
      e = (m == 0) ? 48'h001001001000 : (m == 1) ? 48'h001000001000 : 48'h0;
      chk(p_out, e);
    end
  endtask
  task automatic t_logic();
    logic [47:0] x, y;
    x = 48'hcccccccccccc;
    y = 48'haaaaaaaaaaaa;
    for (int k = 0; k < 12; k++) begin
      bus(1'b1, mas_pkg::OFS_CTRL, BYP | LOG | (k << mas_pkg::C_LFN));
      go(0, 0, 0, y, x, 1);
      case (k)
        0: e = x & y;
        1: e = x | y;
        2: e = x ^ y;
        3: e = ~(x & y);
        4: e = ~(x | y);
        5: e = ~(x ^ y);
        6: e = x & ~y;
        7: e = x | ~y;
        8: e = ~x;
        9: e = x;
        default: e = 48'h0;
      endcase
      chk(p_out, e);
    end
  endtask
  task automatic t_cas();
    @(posedge core_clk);
    ld <= 1'b1;
    ldv <= 48'h123456789abc;
    @(posedge core_clk);
    ld <= 1'b0;
    bus(1'b1, mas_pkg::OFS_CTRL, BYP | (32'h1 << mas_pkg::C_YCAS));
    go(0, 0, 0, 48'h0, 48'h1, 1);
    chk(p_out, 48'h123456789abd);
    chk(cas_out, 48'h123456789abd);
    @(negedge core_clk);
    chk(seen, 48'h123456789abd);
  endtask
  task automatic t_pat();
    bus(1'b1, mas_pkg::OFS_PAT_LO, 32'h12345679);
    bus(1'b1, mas_pkg::OFS_PAT_HI, 32'h00009abc);
    bus(1'b1, mas_pkg::OFS_MSK_LO, 32'h0);
    bus(1'b1, mas_pkg::OFS_MSK_HI, 32'h0);
    bus(1'b1, mas_pkg::OFS_CTRL, BYP);
    go(0, 0, 0, 48'h0, 48'h9abc12345679, 1);
    chk({match_out, nmatch_out}, 48'h2);
    go(0, 0, 0, 48'h0, 48'h6543edcba986, 1);
    chk({match_out, nmatch_out}, 48'h1);
    bus(1'b1, mas_pkg::OFS_CTRL, BYP | LOG | (32'h2 << mas_pkg::C_LFN));
    go(0, 0, 0, 48'h9abc00000000, 48'h000012345679, 1);
    chk(match_out, 48'h1);
    bus(1'b1, mas_pkg::OFS_CTRL, BYP | (32'h1 << mas_pkg::C_RND));
    go(0, 0, 0, 48'h0, 48'h9abc12345679, 1);
    chk(p_out, 48'h9abc12345678);
    bus(1'b0, mas_pkg::OFS_RES_HI, 32'h0);
    chk(rd, 48'h00019abc);
  endtask
  task automatic t_pipe();
    bus(1'b1, mas_pkg::OFS_CTRL, 32'h3 << mas_pkg::C_INP);
    go(0, 0, 0, 48'h0, 48'h0, 4);
    chk(p_out, 48'h0);
    go(25'h2, 0, 18'h3, 48'h0, 48'h0, 2);
    chk(p_out, 48'h0);
    @(negedge core_clk);
    chk(p_out, 48'h6);
  endtask
  task automatic t_count();
    bus(1'b1, mas_pkg::OFS_CTRL, 32'h0);
    go(0, 0, 0, 48'h0, 48'h0, 1);
    @(posedge core_clk);
    acc_en <= 1'b0;
    bus(1'b1, mas_pkg::OFS_STEP, 32'h5);
    bus(1'b1, mas_pkg::OFS_CTRL, CNT);
    en(3);
    chk(p_out, 48'hf);
    bus(1'b1, mas_pkg::OFS_CTRL, CNT | (32'h1 << mas_pkg::C_DOWN));
    en(4);
    chk(p_out, 48'hfffffffffffb);
    bus(1'b1, mas_pkg::OFS_CTRL, BYP | ACC);
    go(0, 0, 0, 48'h0, 48'h7, 1);
    en(2);
    chk(p_out, 48'h9);
  endtask
  // Main sequence; reset is repeated after the last test to see it clear live state
  initial begin
    rst();
    t_reset();
    t_mult();
    t_pre();
    t_simd();
    t_logic();
    t_cas();
    t_pat();
    t_pipe();
    t_count();
    rst();
    t_reset();
    summarize();
  end
endmodule
